// ==== core/exec_defs.svh ====
// Offsets, field positions and reset values for the execution unit.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word a register.
// Function
// - Shift right fills 0 at bit 7, bit 0 to carry, one cycle.
// - Rotate right through carry: old carry to bit 7, bit 0 out.
// - Shift left fills 0 at bit 0, bit 7 to carry, one cycle.
// - Rotate left through carry: old carry to bit 0, bit 7 out.
// - Nibble exchange of working register, one cycle, flags untouched.
// - AND/OR/XOR/NOT/NEG take one cycle, change only zero flag.
// - XOR into port register stores port xor A, no flag change.
// - Compare sets all four flags as a subtraction, stores nothing.
// - Bit clear or set of port or memory byte, one cycle, no flags.
// - Carry exchange drives output bit or samples input bit into carry.
// - Skip-if-equal compares as subtraction and skips on equality.
// - Skip-if-unequal compares likewise and skips on difference.
// - Bit tests skip on bit low or high, flags untouched.
// - Increment or decrement, store, all flags, skip on zero result.
// - Call pushes next address, jumps, stack index plus two, two cycles.
// - Jump loads target into program counter, two cycles.
// - Return drops stack index by two, pops counter; immediate loads A.
// - Interrupt return acts as return then enables interrupts globally.
// - Counter offset jump adds A to program counter, two cycles.
// - Global interrupt enable and disable, one cycle each.
// - Halt-all stops everything; halt-core keeps oscillators running.
// - Software reset resets chip; watchdog clear restarts its count.
// - Bit memory operations only reach data addresses 0 to 0x3F.
// - Carry means unsigned carry out on add, borrow on subtract.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define REG_CMD 8'h00
`define REG_OPND 8'h04
`define REG_ACC 8'h08
`define REG_FLAGS 8'h0c
`define REG_PC 8'h10
`define REG_STK 8'h14
`define REG_STATUS 8'h18
`define REG_CTRL 8'h1c
`define REG_PORT 8'h20
`define REG_DIR 8'h24
`define REG_MADDR 8'h28
`define REG_MDATA 8'h2c

`define CMD_OP_LSB 0
`define CMD_OP_MSB 5
`define CMD_BIT_LSB 8
`define CMD_BIT_MSB 10
`define CMD_ADDR_LSB 16
`define CMD_ADDR_MSB 23

`define FLAG_Z 0
`define FLAG_C 1
`define FLAG_H 2
`define FLAG_V 3

`define ST_GIE 1
`define ST_HALT_ALL 2
`define ST_HALT_CORE 3
`define ST_ERR 4
`define ST_SKIP 5

`define CTRL_WAKE 0
`define CTRL_ERR_CLR 1

`define BIT_MEM_TOP 8'h3f
`define RST_BYTE 8'h00
`define RST_FLAGS 4'h0

`endif

// ==== core/exec_pkg.sv ====
// Types shared by the execution unit: operation codes and sequencer states.
// Assumes exec_defs.svh supplies the register map.
package exec_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_SHR_A, OP_SHR_M, OP_ROR_A, OP_ROR_M, OP_SHL_A, OP_SHL_M,
    OP_ROL_A, OP_ROL_M, OP_NIB_A, OP_AND_AI, OP_AND_AM, OP_AND_MA,
    OP_OR_AI, OP_OR_AM, OP_OR_MA, OP_XOR_AI, OP_XOR_AM, OP_XOR_MA,
    OP_XOR_IOA, OP_NOT_A, OP_NOT_M, OP_NEG_A, OP_NEG_M, OP_CMP_AM,
    OP_CMP_MA, OP_CLR_IO, OP_SET_IO, OP_CLR_M, OP_SET_M, OP_CX_IO,
    OP_CEQ_I, OP_CEQ_M, OP_CNE_I, OP_CNE_M, OP_TLO_IO, OP_THI_IO,
    OP_TLO_M, OP_THI_M, OP_INCZ_A, OP_DECZ_A, OP_INCZ_M, OP_DECZ_M,
    OP_CALL, OP_GOTO, OP_RET_I, OP_RET, OP_RETI, OP_PCADD, OP_GIE_ON,
    OP_GIE_OFF, OP_HALT_ALL, OP_HALT_CORE, OP_SOFT_RST, OP_WDT_CLR
  } op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_SECOND = 3'b100
  } state_e;

endpackage : exec_pkg

// ==== core/exec_unit.sv ====
// Execution unit for shift, logic, bit, skip and system instructions.
// Assumes an Avalon-MM master that holds requests until waitrequest is low.
`timescale 1ns/100ps
`include "exec_defs.svh"

module exec_unit import exec_pkg::*; #(
  parameter int MEM_DEPTH = 128,
  parameter int PC_W = 12,
  parameter int PW = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [PW-1:0] port_a_pin_i,
  output logic [PW-1:0] port_a_out_o,
  output logic [PW-1:0] port_a_oe_n_o,
  output logic gie_o,
  output logic halt_all_o,
  output logic halt_core_o,
  output logic chip_reset_o,
  output logic wdt_clear_o
);

  localparam int MA_W = $clog2(MEM_DEPTH);

  logic [7:0] mem_r [MEM_DEPTH];
  state_e state_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] cmd_r;
  logic [31:0] opnd_r;
  logic [7:0] acc_r;
  logic [3:0] flags_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0] stk_r;
  logic gie_r, halt_all_r, halt_core_r, err_r, skip_r;
  logic rst_r, wdt_r;
  logic [7:0] maddr_r;
  logic [PW-1:0] port_r, oe_n_r;
  logic [PW-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;

  op_e op;
  logic [2:0] bsel;
  logic [7:0] maddr, imm, mask, mem_op, usrc, bsrc, io_rd;
  logic [PC_W-1:0] target, ret_addr;
  logic mem_form, imm_form, bit_ok, wr_ok;
  logic [11:0] cmp_ab, cmp_ba, inc_u, dec_u;

  logic ex_res_we, ex_mem_we, ex_io_we, ex_two, ex_err, ex_skip;
  logic [7:0] ex_res, ex_mem_d, ex_io_d, ex_acc;
  logic ex_acc_we;
  logic [MA_W-1:0] ex_mem_a;
  logic [3:0] ex_flags;
  logic [PC_W-1:0] ex_pc;
  logic [7:0] ex_stk;

  // Flags {v,h,c,z} and result of a - b; carry is unsigned borrow
  function automatic logic [11:0] sub_f(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [8:0] d;
    d = {1'b0, a} - {1'b0, b};
    return {(a[7] ^ b[7]) & (d[7] ^ a[7]), a[3:0] < b[3:0], d[8],
            d[7:0] == 8'h00, d[7:0]};
  endfunction : sub_f

  function automatic logic [11:0] inc_f(input logic [7:0] a);
    logic [7:0] d;
    d = a + 8'h01;
    return {a == 8'h7f, a[3:0] == 4'hf, a == 8'hff, d == 8'h00, d};
  endfunction : inc_f

  assign op = op_e'(cmd_r[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign bsel = cmd_r[`CMD_BIT_MSB:`CMD_BIT_LSB];
  assign maddr = cmd_r[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
  assign imm = opnd_r[7:0];
  assign target = opnd_r[PC_W-1:0];
  assign ret_addr = pc_r + PC_W'(1);
  assign mask = 8'h01 << bsel;
  assign mem_op = mem_r[maddr[MA_W-1:0]];
  assign bit_ok = maddr <= `BIT_MEM_TOP;
  assign io_rd = 8'((~oe_n_r & port_r) | (oe_n_r & pin_r));
  assign mem_form = op inside {OP_SHR_M, OP_ROR_M, OP_SHL_M, OP_ROL_M,
    OP_AND_MA, OP_OR_MA, OP_XOR_MA, OP_NOT_M, OP_NEG_M, OP_INCZ_M,
    OP_DECZ_M};
  assign imm_form = op inside {OP_AND_AI, OP_OR_AI, OP_XOR_AI, OP_CEQ_I,
    OP_CNE_I};
  assign usrc = mem_form ? mem_op : acc_r;
  assign bsrc = imm_form ? imm : mem_op;
  assign cmp_ab = sub_f(acc_r, bsrc);
  assign cmp_ba = sub_f(mem_op, acc_r);
  assign inc_u = inc_f(usrc);
  assign dec_u = sub_f(usrc, 8'h01);

  // Effects of the first execution cycle
  always_comb begin
    ex_res = usrc;
    ex_res_we = 1'b0;
    ex_mem_we = 1'b0;
    ex_mem_a = maddr[MA_W-1:0];
    ex_mem_d = mem_op;
    ex_io_we = 1'b0;
    ex_io_d = io_rd;
    ex_acc_we = 1'b0;
    ex_acc = acc_r;
    ex_flags = flags_r;
    ex_pc = ret_addr;
    ex_stk = stk_r;
    ex_two = 1'b0;
    ex_err = 1'b0;
    ex_skip = 1'b0;
    unique case (op)
      OP_SHR_A, OP_SHR_M: begin
        ex_res = {1'b0, usrc[7:1]};
        ex_flags[`FLAG_C] = usrc[0];
        ex_res_we = 1'b1;
      end
      OP_ROR_A, OP_ROR_M: begin
        ex_res = {flags_r[`FLAG_C], usrc[7:1]};
        ex_flags[`FLAG_C] = usrc[0];
        ex_res_we = 1'b1;
      end
      OP_SHL_A, OP_SHL_M: begin
        ex_res = {usrc[6:0], 1'b0};
        ex_flags[`FLAG_C] = usrc[7];
        ex_res_we = 1'b1;
      end
      OP_ROL_A, OP_ROL_M: begin
        ex_res = {usrc[6:0], flags_r[`FLAG_C]};
        ex_flags[`FLAG_C] = usrc[7];
        ex_res_we = 1'b1;
      end
      OP_NIB_A: begin
        ex_res = {acc_r[3:0], acc_r[7:4]};
        ex_res_we = 1'b1;
      end
      OP_AND_AI, OP_AND_AM, OP_AND_MA, OP_OR_AI, OP_OR_AM, OP_OR_MA,
      OP_XOR_AI, OP_XOR_AM, OP_XOR_MA, OP_NOT_A, OP_NOT_M, OP_NEG_A,
      OP_NEG_M: begin
        if (op inside {OP_AND_AI, OP_AND_AM, OP_AND_MA})
          ex_res = acc_r & bsrc;
        else if (op inside {OP_OR_AI, OP_OR_AM, OP_OR_MA})
          ex_res = acc_r | bsrc;
        else if (op inside {OP_XOR_AI, OP_XOR_AM, OP_XOR_MA})
          ex_res = acc_r ^ bsrc;
        else if (op inside {OP_NOT_A, OP_NOT_M})
          ex_res = ~usrc;
        else
          ex_res = 8'h00 - usrc;
        ex_flags[`FLAG_Z] = ex_res == 8'h00;
        ex_res_we = 1'b1;
      end
      OP_XOR_IOA: begin
        ex_io_d = io_rd ^ acc_r;
        ex_io_we = 1'b1;
      end
      OP_CMP_AM: ex_flags = cmp_ab[11:8];
      OP_CMP_MA: ex_flags = cmp_ba[11:8];
      OP_CLR_IO, OP_SET_IO: begin
        ex_io_d = (op == OP_SET_IO) ? (io_rd | mask) : (io_rd & ~mask);
        ex_io_we = 1'b1;
      end
      OP_CLR_M, OP_SET_M: begin
        ex_mem_d = (op == OP_SET_M) ? (mem_op | mask) : (mem_op & ~mask);
        ex_mem_we = bit_ok;
        ex_err = !bit_ok;
      end
      OP_CX_IO: begin
        if (!oe_n_r[bsel]) begin
          ex_io_d[bsel] = flags_r[`FLAG_C];
          ex_io_we = 1'b1;
        end else begin
          ex_flags[`FLAG_C] = pin_r[bsel];
        end
      end
      OP_CEQ_I, OP_CEQ_M, OP_CNE_I, OP_CNE_M: begin
        ex_flags = cmp_ab[11:8];
        ex_skip = (op inside {OP_CEQ_I, OP_CEQ_M}) ?
                  cmp_ab[`FLAG_Z+8] : !cmp_ab[`FLAG_Z+8];
      end
      OP_TLO_IO, OP_THI_IO: begin
        ex_skip = io_rd[bsel] == (op == OP_THI_IO);
      end
      OP_TLO_M, OP_THI_M: begin
        ex_skip = bit_ok && (mem_op[bsel] == (op == OP_THI_M));
        ex_err = !bit_ok;
      end
      OP_INCZ_A, OP_INCZ_M, OP_DECZ_A, OP_DECZ_M: begin
        if (op inside {OP_INCZ_A, OP_INCZ_M}) begin
          ex_res = inc_u[7:0];
          ex_flags = inc_u[11:8];
        end else begin
          ex_res = dec_u[7:0];
          ex_flags = dec_u[11:8];
        end
        ex_res_we = 1'b1;
        ex_skip = ex_res == 8'h00;
      end
      OP_CALL: begin
        ex_mem_a = stk_r[MA_W-1:0];
        ex_mem_d = ret_addr[7:0];
        ex_mem_we = 1'b1;
        ex_pc = pc_r;
        ex_two = 1'b1;
      end
      OP_GOTO: begin
        ex_pc = target;
        ex_two = 1'b1;
      end
      OP_RET_I, OP_RET, OP_RETI: begin
        ex_stk = stk_r - 8'h02;
        ex_pc = pc_r;
        ex_two = 1'b1;
        if (op == OP_RET_I) begin
          ex_acc = imm;
          ex_acc_we = 1'b1;
        end
      end
      OP_PCADD: begin
        ex_pc = pc_r + PC_W'(acc_r);
        ex_two = 1'b1;
      end
      OP_NOP, OP_GIE_ON, OP_GIE_OFF, OP_HALT_ALL, OP_HALT_CORE,
      OP_SOFT_RST, OP_WDT_CLR: ex_two = 1'b0;
      default: ex_err = 1'b1;
    endcase
    if (ex_res_we) begin
      if (mem_form) begin
        ex_mem_d = ex_res;
        ex_mem_we = 1'b1;
      end else begin
        ex_acc = ex_res;
        ex_acc_we = 1'b1;
      end
    end
    if (ex_skip) begin
      ex_pc = pc_r + PC_W'(2);
      ex_two = 1'b1;
    end
  end

  // Bus answers only while idle; everything stalls during execution
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && state_r == ST_IDLE) begin
      wait_r <= 1'b0;
      unique case (avs_address_i)
        `REG_CMD: rdata_r <= cmd_r;
        `REG_OPND: rdata_r <= opnd_r;
        `REG_ACC: rdata_r <= {24'h000000, acc_r};
        `REG_FLAGS: rdata_r <= {28'h0000000, flags_r};
        `REG_PC: rdata_r <= 32'(pc_r);
        `REG_STK: rdata_r <= {24'h000000, stk_r};
        `REG_STATUS: rdata_r <= {26'h0, skip_r, err_r, halt_core_r,
                                 halt_all_r, gie_r, 1'b0};
        `REG_PORT: rdata_r <= 32'(io_rd);
        `REG_DIR: rdata_r <= 32'(~oe_n_r);
        `REG_MADDR: rdata_r <= {24'h000000, maddr_r};
        `REG_MDATA: rdata_r <= {24'h000000, mem_r[maddr_r[MA_W-1:0]]};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wr_ok = avs_write_i && !wait_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (wr_ok && avs_address_i == `REG_CMD &&
                     !halt_all_r && !halt_core_r) state_r <= ST_EXEC;
        ST_EXEC: state_r <= ex_two ? ST_SECOND : ST_IDLE;
        ST_SECOND: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_r <= 32'h0000_0000;
      opnd_r <= 32'h0000_0000;
      maddr_r <= `RST_BYTE;
    end else if (wr_ok) begin
      if (avs_address_i == `REG_CMD) cmd_r <= avs_writedata_i;
      if (avs_address_i == `REG_OPND) opnd_r <= avs_writedata_i;
      if (avs_address_i == `REG_MADDR) maddr_r <= avs_writedata_i[7:0];
    end
  end

  // Architectural state, cleared again by the software reset pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_r <= `RST_BYTE;
      flags_r <= `RST_FLAGS;
      pc_r <= '0;
      stk_r <= `RST_BYTE;
      skip_r <= 1'b0;
    end else if (rst_r) begin
      acc_r <= `RST_BYTE;
      flags_r <= `RST_FLAGS;
      pc_r <= '0;
      stk_r <= `RST_BYTE;
      skip_r <= 1'b0;
    end else if (state_r == ST_EXEC) begin
      if (ex_acc_we) acc_r <= ex_acc;
      flags_r <= ex_flags;
      pc_r <= ex_pc;
      stk_r <= ex_stk;
      skip_r <= ex_skip;
    end else if (state_r == ST_SECOND) begin
      if (op == OP_CALL) begin
        pc_r <= target;
        stk_r <= stk_r + 8'h02;
      end else if (op inside {OP_RET, OP_RET_I, OP_RETI}) begin
        pc_r <= PC_W'({mem_r[MA_W'(stk_r + 8'h01)], mem_r[stk_r[MA_W-1:0]]});
      end
    end else if (wr_ok) begin
      if (avs_address_i == `REG_ACC) acc_r <= avs_writedata_i[7:0];
      if (avs_address_i == `REG_FLAGS) flags_r <= avs_writedata_i[3:0];
      if (avs_address_i == `REG_PC) pc_r <= avs_writedata_i[PC_W-1:0];
      if (avs_address_i == `REG_STK) stk_r <= avs_writedata_i[7:0];
    end
  end

  // Data memory; stack and bit operations share it
  always_ff @(posedge clk_i) begin
    if (state_r == ST_EXEC && ex_mem_we)
      mem_r[ex_mem_a] <= ex_mem_d;
    else if (state_r == ST_SECOND && op == OP_CALL)
      mem_r[MA_W'(stk_r + 8'h01)] <= 8'(ret_addr >> 8);
    else if (wr_ok && avs_address_i == `REG_MDATA)
      mem_r[maddr_r[MA_W-1:0]] <= avs_writedata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_r <= '0;
      oe_n_r <= '1;
    end else if (rst_r) begin
      port_r <= '0;
      oe_n_r <= '1;
    end else if (state_r == ST_EXEC && ex_io_we) begin
      port_r <= PW'(ex_io_d);
    end else if (wr_ok) begin
      if (avs_address_i == `REG_PORT) port_r <= avs_writedata_i[PW-1:0];
      if (avs_address_i == `REG_DIR) oe_n_r <= ~avs_writedata_i[PW-1:0];
    end
  end

  // Pin level accepted once the second and third stages agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= port_a_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= (pin_s3_r & ~(pin_s2_r ^ pin_s3_r)) |
               (pin_r & (pin_s2_r ^ pin_s3_r));
    end
  end

  // System control; a halt is left only by a wake write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gie_r <= 1'b0;
      halt_all_r <= 1'b0;
      halt_core_r <= 1'b0;
      err_r <= 1'b0;
      rst_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      rst_r <= state_r == ST_EXEC && op == OP_SOFT_RST;
      wdt_r <= state_r == ST_EXEC && op == OP_WDT_CLR;
      if (rst_r) begin
        gie_r <= 1'b0;
        halt_all_r <= 1'b0;
        halt_core_r <= 1'b0;
      end else if (state_r == ST_EXEC) begin
        if (op == OP_GIE_ON) gie_r <= 1'b1;
        if (op == OP_GIE_OFF) gie_r <= 1'b0;
        if (op == OP_HALT_ALL) halt_all_r <= 1'b1;
        if (op == OP_HALT_CORE) halt_core_r <= 1'b1;
      end else if (state_r == ST_SECOND && op == OP_RETI) begin
        gie_r <= 1'b1;
      end else if (wr_ok && avs_address_i == `REG_CTRL &&
                   avs_writedata_i[`CTRL_WAKE]) begin
        halt_all_r <= 1'b0;
        halt_core_r <= 1'b0;
      end
      if (state_r == ST_EXEC && ex_err)
        err_r <= 1'b1;
      else if (wr_ok && avs_address_i == `REG_CTRL &&
               avs_writedata_i[`CTRL_ERR_CLR])
        err_r <= 1'b0;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign port_a_out_o = port_r;
  assign port_a_oe_n_o = oe_n_r;
  assign gie_o = gie_r;
  assign halt_all_o = halt_all_r;
  assign halt_core_o = halt_core_r;
  assign chip_reset_o = rst_r;
  assign wdt_clear_o = wdt_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_exec(op_e o);
    state_r == ST_EXEC && op == o && !rst_r;
  endsequence
  sequence s_two_phase;
    state_r == ST_SECOND ##1 state_r == ST_IDLE;
  endsequence

  a_shr_zero_fill: assert property (s_exec(OP_SHR_A) |=>
    acc_r == {1'b0, $past(acc_r[7:1])} && flags_r[`FLAG_C] == $past(acc_r[0])
    && flags_r[`FLAG_Z] == $past(flags_r[`FLAG_Z]))
    else $error("shift right result wrong");
  a_rol_carry_in: assert property (s_exec(OP_ROL_A) |=>
    acc_r == {$past(acc_r[6:0]), $past(flags_r[`FLAG_C])})
    else $error("rotate left result wrong");
  a_nibble_flags: assert property (s_exec(OP_NIB_A) |=>
    $stable(flags_r) && acc_r == {$past(acc_r[3:0]), $past(acc_r[7:4])})
    else $error("nibble swap wrong");
  a_xor_io_flags: assert property (s_exec(OP_XOR_IOA) |=>
    $stable(flags_r) && port_r == PW'($past(io_rd) ^ $past(acc_r)))
    else $error("port xor wrong");
  a_cmp_no_store: assert property (s_exec(OP_CMP_AM) |=>
    $stable(acc_r) && flags_r[`FLAG_C] == ($past(acc_r) < $past(mem_op)))
    else $error("compare stored or bad borrow");
  a_skip_two_cycles: assert property ((state_r == ST_EXEC && ex_skip)
    |=> s_two_phase) else $error("skip did not take two cycles");
  a_call_push_sp: assert property (s_exec(OP_CALL) |=>
    s_two_phase and ##1 (stk_r == $past(stk_r, 2) + 8'h02 &&
    pc_r == target)) else $error("call stack or target wrong");
  a_reti_enables: assert property (s_exec(OP_RETI) |=>
    state_r == ST_SECOND ##1 gie_r) else $error("reti left gie low");
  a_bit_mem_limit: assert property ((state_r == ST_EXEC &&
    op inside {OP_CLR_M, OP_SET_M} && maddr > `BIT_MEM_TOP) |-> !ex_mem_we
    ##1 err_r) else $error("bit op beyond limit");

endmodule : exec_unit

// ==== tb/mcu_shift_logic_branch_exec_bench.sv ====
// Self-checking bench: drives the execution unit over its register bus.
// Assumes exec_pkg compiled first and exec_defs.svh on the include path.
`timescale 1ns/100ps
`include "exec_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  error_cnt++; $display("unexpected t=%0t got %h exp %h", $time, g, e); \
  end end
module mcu_shift_logic_branch_exec_bench import exec_pkg::*; ;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic wt;
  logic [7:0] pin = 8'h00;
  logic [7:0] pout;
  logic [7:0] oe_n;
  logic gie, hall, hcore, crst, wclr;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 44641;
  int npulse = 0;
  int a, m, i, f, n, ad, p, x, y, c, bn, ea, em, ef, ep, sk, pc, n0;
  // Return addresses the model expects the stack to give back
  int stk_q[$];
  op_e o;

  always #12.5 clk_i = ~clk_i;
  // Pulses are one cycle wide, so count them instead of polling
  always @(posedge clk_i) npulse <= npulse + int'(wclr) + int'(crst);

  exec_unit DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_readdata_o(q), .avs_waitrequest_o(wt), .port_a_pin_i(pin),
    .port_a_out_o(pout), .port_a_oe_n_o(oe_n), .gie_o(gie),
    .halt_all_o(hall), .halt_core_o(hcore), .chip_reset_o(crst),
    .wdt_clear_o(wclr));

  task automatic bus(input logic w, input logic [7:0] ad_i,
                     input logic [31:0] d);
    adr <= ad_i;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_i);
    while (wt !== 1'b0) @(posedge clk_i);
    rdat = q;
    wr <= 1'b0;
    rd <= 1'b0;
    // One idle edge so a strobe is never re-driven in the same step
    @(posedge clk_i);
  endtask : bus

  task automatic wrr(input logic [7:0] ad_i, input logic [31:0] d);
    bus(1'b1, ad_i, d);
  endtask : wrr

  task automatic rdr(input logic [7:0] ad_i);
    bus(1'b0, ad_i, 32'h0);
  endtask : rdr

  // Status read afterwards stalls until the instruction has finished
  task automatic ex(input op_e op, input logic [2:0] b, input logic [7:0] ma);
    wrr(`REG_CMD, {8'h00, ma, 5'h00, b, 2'h0, op});
    rdr(`REG_STATUS);
  endtask : ex

  function automatic int subf(int u, int v);
    int s;
    s = (u - v) & 255;
    return (s == 0 ? 1 : 0) + (u < v ? 2 : 0) + ((u & 15) < (v & 15) ? 4 : 0)
      + (((u ^ v) & (u ^ s) & 128) != 0 ? 8 : 0);
  endfunction : subf

  function automatic int addf(int u, int v);
    int s;
    s = (u + v) & 255;
    return (s == 0 ? 1 : 0) + (u + v > 255 ? 2 : 0)
      + ((u & 15) + (v & 15) > 15 ? 4 : 0)
      + ((~(u ^ v) & (u ^ s) & 128) != 0 ? 8 : 0);
  endfunction : addf

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(25 * 60000);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rdr(`REG_ACC); `CHK(rdat, 32'h0)
    rdr(`REG_STATUS); `CHK(rdat, 32'h0)
    rdr(8'h3c); `CHK(rdat, 32'h0)
    `CHK(oe_n, 8'hff)
    wrr(`REG_DIR, 32'hff); `CHK(oe_n, 8'h00)
    $display("test reset done");
    for (int k = 0; k < 210; k++) begin
      o = op_e'(1 + k % 42);
      if (o == OP_CX_IO) continue;
      a = $random(seed) & 255; m = $random(seed) & 255;
      i = $random(seed) & 255; f = $random(seed) & 15;
      n = $random(seed) & 7; ad = $random(seed) & 63;
      p = $random(seed) & 255;
      if (k % 4 == 0) m = a;
      if (k % 5 == 0) a = 255;
      if (k % 7 == 0) m = 1;
      pin <= 8'($random(seed));
      wrr(`REG_ACC, a); wrr(`REG_FLAGS, f); wrr(`REG_OPND, i);
      wrr(`REG_MADDR, ad); wrr(`REG_MDATA, m); wrr(`REG_PORT, p);
      rdr(`REG_PC); pc = rdat;
      ea = a; em = m; ef = f; ep = p; sk = 0; y = 0;
      c = (f >> 1) & 1; bn = 1 << n;
      if (o <= OP_ROL_M) begin
        x = (o % 2) ? a : m;
        if (o > OP_ROR_M) y = ((x << 1) & 255) | (o >= OP_ROL_A ? c : 0);
        else y = (x >> 1) | (o >= OP_ROR_A ? c << 7 : 0);
        ef = (f & 13) + 2 * (o > OP_ROR_M ? x >> 7 : x & 1);
        if (o % 2) ea = y; else em = y;
      end else case (o)
        OP_NIB_A: ea = ((a << 4) | (a >> 4)) & 255;
        OP_AND_AI: y = a & i;
        OP_AND_AM, OP_AND_MA: y = a & m;
        OP_OR_AI: y = a | i;
        OP_OR_AM, OP_OR_MA: y = a | m;
        OP_XOR_AI: y = a ^ i;
        OP_XOR_AM, OP_XOR_MA: y = a ^ m;
        OP_XOR_IOA: ep = p ^ a;
        OP_NOT_A: y = ~a & 255;
        OP_NOT_M: y = ~m & 255;
        OP_NEG_A: y = -a & 255;
        OP_NEG_M: y = -m & 255;
        OP_CMP_AM: ef = subf(a, m);
        OP_CMP_MA: ef = subf(m, a);
        OP_CLR_IO: ep = p & ~bn;
        OP_SET_IO: ep = p | bn;
        OP_CLR_M: em = m & ~bn;
        OP_SET_M: em = m | bn;
        OP_CEQ_I, OP_CNE_I: begin
          ef = subf(a, i);
          sk = (a == i) ^ (o == OP_CNE_I);
        end
        OP_CEQ_M, OP_CNE_M: begin
          ef = subf(a, m);
          sk = (a == m) ^ (o == OP_CNE_M);
        end
        OP_TLO_IO, OP_THI_IO: sk = ((p & bn) != 0) ^ (o == OP_TLO_IO);
        OP_TLO_M, OP_THI_M: sk = ((m & bn) != 0) ^ (o == OP_TLO_M);
        OP_INCZ_A, OP_INCZ_M: begin
          x = (o == OP_INCZ_A) ? a : m;
          y = (x + 1) & 255;
          ef = addf(x, 1);
        end
        OP_DECZ_A, OP_DECZ_M: begin
          x = (o == OP_DECZ_A) ? a : m;
          y = (x - 1) & 255;
          ef = subf(x, 1);
        end
        default: ;
      endcase
      if (o >= OP_AND_AI && o <= OP_NEG_M && o != OP_XOR_IOA) begin
        ef = (f & 14) + (y == 0 ? 1 : 0);
        if (o inside {OP_AND_MA, OP_OR_MA, OP_XOR_MA, OP_NOT_M, OP_NEG_M})
          em = y;
        else ea = y;
      end
      if (o >= OP_INCZ_A) begin
        sk = (y == 0);
        if (o >= OP_INCZ_M) em = y; else ea = y;
      end
      ex(o, 3'(n), 8'(ad));
      `CHK(rdat[5], 1'(sk))
      rdr(`REG_ACC); `CHK(rdat[7:0], 8'(ea))
      rdr(`REG_FLAGS); `CHK(rdat[3:0], 4'(ef))
      rdr(`REG_MDATA); `CHK(rdat[7:0], 8'(em))
      rdr(`REG_PC); `CHK(rdat[11:0], 12'(pc + 1 + sk))
      `CHK(pout, 8'(ep))
    end
    $display("test random ops done");
    wrr(`REG_STK, 32'h40); wrr(`REG_OPND, 32'h15a);
    rdr(`REG_PC); pc = rdat;
    ex(OP_CALL, 3'h0, 8'h00);
    stk_q.push_back(pc + 1);
    rdr(`REG_PC); `CHK(rdat[11:0], 12'h15a)
    rdr(`REG_STK); `CHK(rdat[7:0], 8'h42)
    wrr(`REG_MADDR, 32'h40); rdr(`REG_MDATA);
    `CHK(rdat[7:0], 8'(pc + 1))
    wrr(`REG_MADDR, 32'h41); rdr(`REG_MDATA);
    `CHK(rdat[7:0], 8'((pc + 1) >> 8))
    ex(OP_GIE_OFF, 3'h0, 8'h00); `CHK(gie, 1'b0)
    ex(OP_RETI, 3'h0, 8'h00); `CHK(gie, 1'b1)
    rdr(`REG_PC); `CHK(rdat[11:0], 12'(stk_q.pop_back()))
    rdr(`REG_STK); `CHK(rdat[7:0], 8'h40)
    ex(OP_GIE_OFF, 3'h0, 8'h00);
    ex(OP_GIE_ON, 3'h0, 8'h00); `CHK(rdat[1], 1'b1)
    ex(OP_CALL, 3'h0, 8'h00);
    ex(OP_RET_I, 3'h0, 8'h00);
    rdr(`REG_ACC); `CHK(rdat[7:0], 8'h5a)
    wrr(`REG_OPND, 32'h2a5); ex(OP_GOTO, 3'h0, 8'h00);
    rdr(`REG_PC); `CHK(rdat[11:0], 12'h2a5)
    wrr(`REG_ACC, 32'h83); ex(OP_PCADD, 3'h0, 8'h00);
    rdr(`REG_PC); `CHK(rdat[11:0], 12'h328)
    $display("test flow done");
    for (int h = 0; h < 2; h++) begin
      ex(h ? OP_HALT_CORE : OP_HALT_ALL, 3'h0, 8'h00);
      `CHK({hall, hcore}, h ? 2'b01 : 2'b10)
      wrr(`REG_ACC, 32'h05); ex(OP_NOT_A, 3'h0, 8'h00);
      rdr(`REG_ACC); `CHK(rdat[7:0], 8'h05)
      wrr(`REG_CTRL, 32'h1); `CHK({hall, hcore}, 2'b00)
    end
    wrr(`REG_MADDR, 32'h50); wrr(`REG_MDATA, 32'h0);
    ex(OP_SET_M, 3'h3, 8'h50); `CHK(rdat[4], 1'b1)
    rdr(`REG_MDATA); `CHK(rdat[7:0], 8'h00)
    ex(OP_TLO_M, 3'h3, 8'h50); `CHK(rdat[5:4], 2'b01)
    wrr(`REG_CTRL, 32'h2); rdr(`REG_STATUS); `CHK(rdat[4], 1'b0)
    rdr(`REG_PC);
    pc = rdat;
    ex(OP_NOP, 3'h0, 8'h00);
    ex(op_e'(6'h3f), 3'h0, 8'h00);
    `CHK(rdat[4], 1'b1)
    rdr(`REG_PC); `CHK(rdat[11:0], 12'(pc + 2))
    wrr(`REG_CTRL, 32'h2);
    wrr(`REG_DIR, 32'hfe); pin <= 8'h01; wrr(`REG_FLAGS, 32'h0);
    ex(OP_CX_IO, 3'h0, 8'h00);
    rdr(`REG_FLAGS); `CHK(rdat[1], 1'b1)
    wrr(`REG_DIR, 32'hff); wrr(`REG_PORT, 32'h0); wrr(`REG_FLAGS, 32'h2);
    ex(OP_CX_IO, 3'h0, 8'h00); `CHK(pout[0], 1'b1)
    n0 = npulse; ex(OP_WDT_CLR, 3'h0, 8'h00);
    `CHK(npulse, n0 + 1)
    wrr(`REG_ACC, 32'h77); ex(OP_SOFT_RST, 3'h0, 8'h00);
    `CHK(npulse, n0 + 2)
    rdr(`REG_ACC); `CHK(rdat[7:0], 8'h00)
    rdr(`REG_PC); `CHK(rdat[11:0], 12'h000)
    $display("test system done");
    finish_test();
  end
endmodule : mcu_shift_logic_branch_exec_bench
